/* rtl/aptsm_consts.svh */
// register offsets, field positions and reset values of the tx slot mapper
`ifndef APTSM_CONSTS_SVH
`define APTSM_CONSTS_SVH
`define APTSM_IDX_FMT 6'h1A
`define APTSM_IDX_OFFSET 6'h1C
`define APTSM_IDX_ROUTE 6'h1D
`define APTSM_IDX_CH1 6'h1E
`define APTSM_IDX_STATUS 6'h30
`define APTSM_RST_FMT 8'h00
`define APTSM_RST_OFFSET 8'h00
`define APTSM_RST_ROUTE 8'h00
`define APTSM_RST_CH1 8'h20
`define APTSM_MASK_FMT 8'hC0
`define APTSM_MASK_OFFSET 8'h1F
`define APTSM_MASK_CH1 8'h3F
`define APTSM_FMT_LSB 6
`define APTSM_CH1_EN_BIT 5
`define APTSM_I2S_DELAY 12'h001
`define APTSM_SLOTS_LR 12'h010
`define APTSM_SLOTS_TDM 12'h020
`define APTSM_LR_SLOT_BASE 5'h10
`define APTSM_OTHER_EN 7'h7F
`endif

/* rtl/aptsm_lane.sv */
// one output channel: slot match and bit pick
`timescale 1ns/1ps
`default_nettype none
module aptsm_lane
   import aptsm_pkg::*;
#(
   parameter int W = 32,
   parameter int LW = 5
)(
   input wire logic in_frame,
   input wire aptsm_slot_t slot_now,
   input wire logic [LW-1:0] bit_now,
   input wire logic lane_en,
   input wire aptsm_slot_t lane_slot,
   input wire logic [W-1:0] word,
   output logic hit,
   output logic bit_val
);
   assign hit = in_frame && lane_en && (slot_now == lane_slot);
   assign bit_val = word[bit_now];
endmodule : aptsm_lane
`default_nettype wire

/* rtl/aptsm_pkg.sv */
// types shared by the tx slot mapper
package aptsm_pkg;
   typedef enum logic [1:0] {
      APTSM_TDM = 2'b00,
      APTSM_I2S = 2'b01,
      APTSM_LJ = 2'b10,
      APTSM_RSV = 2'b11
   } aptsm_fmt_e;
   typedef logic [4:0] aptsm_slot_t;
endpackage : aptsm_pkg

/* rtl/aptsm_top.sv */
// transmit slot mapper of the primary audio port with wishbone registers
//
// How it works
// - slot 0 msb is delayed by the 5-bit offset field in bit-clock cycles, zero meaning standard position.
// - the offset applies to both data pins and shifts left and right slot 0 equally in i2s and lj.
// - route bit n-1 sends channel n to pin a when 0 and to pin b when 1.
// - channel 1 enable bit 5 resets to 1; 0 tri-states its slot, 1 sends channel 1 data.
// - channel 1 slot number is slot 0-31 in tdm, left 0-15 or right 0-15 (values 16-31) in i2s and lj.
// - format code 0 is tdm, 1 i2s, 2 lj, 3 reserved and idle.
`include "aptsm_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module aptsm_top
   import aptsm_pkg::*;
#(
   parameter int SLOT_BITS = 32,
   parameter int HALF_BITS = 512
)(
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic CYC_I,
   input wire logic STB_I,
   input wire logic WE_I,
   input wire logic [7:0] ADR_I,
   input wire logic [3:0] SEL_I,
   input wire logic [31:0] DAT_I,
   output logic [31:0] DAT_O,
   output logic ACK_O,
   input wire logic FSYNC,
   input wire logic [8*SLOT_BITS-1:0] CH_DATA,
   output logic DOUT_A,
   output logic DOUT_A_OE_N,
   output logic SERIAL_OUT_B,
   output logic SERIAL_OUT_B_OE_N
);
   localparam int LW = $clog2(SLOT_BITS);
   localparam logic [11:0] W12 = 12'(SLOT_BITS);
   localparam logic [11:0] HALF12 = 12'(HALF_BITS);
   localparam logic [11:0] CNT_MAX = 12'hFFF;

   // refuse sizes the counter and lanes cannot serve
   if (SLOT_BITS < 2 || SLOT_BITS > 32 || (1 << LW) != SLOT_BITS)
   begin : g_bad_slot_bits
      $error("slot width must be a power of two from 2 to 32");
   end
   if (HALF_BITS < 16 * SLOT_BITS || HALF_BITS > 1024)
   begin : g_bad_half_bits
      $error("half frame must hold 16 slots and fit 1024 bits");
   end

   logic [7:0] fmt_reg;
   logic [7:0] offset_reg;
   logic [7:0] route_reg;
   logic [7:0] ch1_reg;
   logic [11:0] cnt;
   logic [SLOT_BITS-1:0] held [8];
   logic [SLOT_BITS-1:0] word_now [8];
   logic [11:0] cnt_now;
   logic [11:0] pos;
   logic [11:0] lead;
   logic in_frame;
   aptsm_slot_t slot_now;
   logic [LW-1:0] bit_now;
   aptsm_fmt_e fmt;
   logic [7:0] lane_en;
   aptsm_slot_t lane_slot [8];
   logic [7:0] hit;
   logic [7:0] bits;
   logic wr;
   logic [5:0] idx;

   // register bus
   assign idx = ADR_I[7:2];
   assign wr = CYC_I && STB_I && WE_I && !ACK_O && SEL_I[0];

   always_ff @(posedge CLK)
   begin
      if (!RSTN)
         ACK_O <= 1'b0;
      else
         ACK_O <= CYC_I && STB_I && !ACK_O;
   end

   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         fmt_reg <= `APTSM_RST_FMT;
         offset_reg <= `APTSM_RST_OFFSET;
         route_reg <= `APTSM_RST_ROUTE;
         ch1_reg <= `APTSM_RST_CH1;
      end
      else if (wr)
      begin
         unique case (idx)
            `APTSM_IDX_FMT: fmt_reg <= DAT_I[7:0] & `APTSM_MASK_FMT;
            `APTSM_IDX_OFFSET: offset_reg <= DAT_I[7:0] & `APTSM_MASK_OFFSET;
            `APTSM_IDX_ROUTE: route_reg <= DAT_I[7:0];
            `APTSM_IDX_CH1: ch1_reg <= DAT_I[7:0] & `APTSM_MASK_CH1;
            default: ;
         endcase
      end
   end

   always_ff @(posedge CLK)
   begin
      if (!RSTN)
         DAT_O <= 32'h00000000;
      else if (CYC_I && STB_I && !ACK_O)
      begin
         unique case (idx)
            `APTSM_IDX_FMT: DAT_O <= {24'h000000, fmt_reg};
            `APTSM_IDX_OFFSET: DAT_O <= {24'h000000, offset_reg};
            `APTSM_IDX_ROUTE: DAT_O <= {24'h000000, route_reg};
            `APTSM_IDX_CH1: DAT_O <= {24'h000000, ch1_reg};
            `APTSM_IDX_STATUS: DAT_O <= {24'h000000, !DOUT_A_OE_N, !SERIAL_OUT_B_OE_N, in_frame, slot_now};
            default: DAT_O <= 32'h00000000;
         endcase
      end
   end

   // frame bit counter, idle at its maximum
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
         cnt <= CNT_MAX;
      else if (FSYNC)
         cnt <= 12'h001;
      else if (cnt != CNT_MAX)
         cnt <= cnt + 12'h001;
   end

   always_ff @(posedge CLK)
   begin
      if (FSYNC)
         for (int k = 0; k < 8; k++)
            held[k] <= CH_DATA[k*SLOT_BITS +: SLOT_BITS];
   end

   always_comb
   begin
      for (int k = 0; k < 8; k++)
         word_now[k] = FSYNC ? CH_DATA[k*SLOT_BITS +: SLOT_BITS] : held[k];
   end

   // position inside the frame after offset
   assign cnt_now = FSYNC ? 12'h000 : cnt;
   assign fmt = aptsm_fmt_e'(fmt_reg[`APTSM_FMT_LSB +: 2]);

   always_comb
   begin
      lead = {7'h00, offset_reg[4:0]};
      pos = 12'h000;
      in_frame = 1'b0;
      slot_now = 5'h00;
      unique case (fmt)
         APTSM_TDM:
         begin
            pos = cnt_now - lead;
            in_frame = (cnt_now != CNT_MAX) && (cnt_now >= lead) && (pos < `APTSM_SLOTS_TDM * W12);
            slot_now = 5'(pos >> LW);
         end
         APTSM_I2S, APTSM_LJ:
         begin
            if (fmt == APTSM_I2S)
               lead = lead + `APTSM_I2S_DELAY;
            // left slot 15 tail runs until the shifted right msb
            if (cnt_now >= HALF12 + lead)
            begin
               pos = cnt_now - HALF12 - lead;
               in_frame = (cnt_now != CNT_MAX) && (cnt_now >= HALF12 + lead) && (pos < `APTSM_SLOTS_LR * W12);
               slot_now = `APTSM_LR_SLOT_BASE | 5'(pos >> LW);
            end
            else
            begin
               pos = cnt_now - lead;
               in_frame = (cnt_now >= lead) && (pos < `APTSM_SLOTS_LR * W12);
               slot_now = 5'(pos >> LW);
            end
         end
         APTSM_RSV: in_frame = 1'b0;
      endcase
      bit_now = LW'(W12 - 12'h001 - 12'(pos[LW-1:0]));
   end

   // channel lanes
   assign lane_en = {`APTSM_OTHER_EN, ch1_reg[`APTSM_CH1_EN_BIT]};

   genvar g;
   generate
      for (g = 0; g < 8; g++)
      begin : g_lane
         if (g == 0)
         begin : g_ch1
            assign lane_slot[g] = ch1_reg[4:0];
         end
         else
         begin : g_other
            assign lane_slot[g] = 5'(g);
         end
         aptsm_lane #(.W(SLOT_BITS), .LW(LW)) u_lane (
            .in_frame(in_frame),
            .slot_now(slot_now),
            .bit_now(bit_now),
            .lane_en(lane_en[g]),
            .lane_slot(lane_slot[g]),
            .word(word_now[g]),
            .hit(hit[g]),
            .bit_val(bits[g])
         );
      end
   endgenerate

   // pin routing and output stage
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         DOUT_A <= 1'b0;
         DOUT_A_OE_N <= 1'b1;
         SERIAL_OUT_B <= 1'b0;
         SERIAL_OUT_B_OE_N <= 1'b1;
      end
      else
      begin
         DOUT_A <= |(hit & ~route_reg & bits);
         DOUT_A_OE_N <= ~|(hit & ~route_reg);
         SERIAL_OUT_B <= |(hit & route_reg & bits);
         SERIAL_OUT_B_OE_N <= ~|(hit & route_reg);
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RSTN);

   a_tdm_msb_place: assert property (fmt == APTSM_TDM && cnt_now == {7'h00, offset_reg[4:0]}
      |-> in_frame && slot_now == 5'h00 && bit_now == LW'(SLOT_BITS - 1))
      else $error("tdm slot 0 msb not at offset");
   a_right_msb_shift: assert property (fmt == APTSM_LJ && cnt_now == HALF12 + {7'h00, offset_reg[4:0]}
      |-> in_frame && slot_now == `APTSM_LR_SLOT_BASE && bit_now == LW'(SLOT_BITS - 1))
      else $error("right slot 0 not shifted by offset");
   a_i2s_left_shift: assert property (fmt == APTSM_I2S && cnt_now == {7'h00, offset_reg[4:0]} + 12'h001
      |-> in_frame && slot_now == 5'h00)
      else $error("i2s left slot 0 misplaced");
   a_pin_a_route: assert property (hit[0] && !route_reg[0] |=> !DOUT_A_OE_N && DOUT_A == $past(bits[0]))
      else $error("channel 1 not on pin a");
   a_pin_b_route: assert property (hit[0] && route_reg[0] |=> !SERIAL_OUT_B_OE_N && SERIAL_OUT_B == $past(bits[0]))
      else $error("channel 1 not on pin b");
   a_ch1_tristate: assert property (!ch1_reg[`APTSM_CH1_EN_BIT] |-> !hit[0])
      else $error("disabled channel 1 drives");
   a_ch1_slot_match: assert property (hit[0] |-> slot_now == ch1_reg[4:0] && in_frame)
      else $error("channel 1 outside its slot");
   a_rsv_format_idle: assert property (fmt == APTSM_RSV [*2] |=> DOUT_A_OE_N && SERIAL_OUT_B_OE_N)
      else $error("reserved format drives pins");
   a_reserved_zero: assert property (ACK_O && $past(idx) == `APTSM_IDX_CH1 |-> DAT_O[7:6] == 2'b00)
      else $error("reserved bits read nonzero");

   c_tdm_frame: cover property (fmt == APTSM_TDM && hit[0] ##1 !DOUT_A_OE_N);
   c_i2s_right: cover property (fmt == APTSM_I2S && hit[0] && slot_now >= `APTSM_LR_SLOT_BASE);
   c_pin_b: cover property (!SERIAL_OUT_B_OE_N);
   c_offset_max: cover property (offset_reg[4:0] == 5'h1F && hit[0]);
endmodule : aptsm_top
`default_nettype wire

/* verification/aptsm_host_rx.sv */
// host receiver model capturing both data pins per bit position
`timescale 1ns/1ps
`default_nettype none
module aptsm_host_rx (
   input wire logic clk,
   input wire logic fsync,
   input wire logic pin_a,
   input wire logic pin_a_oe_n,
   input wire logic pin_b,
   input wire logic pin_b_oe_n
);
   logic [511:0] a_d, a_oe_n, b_d, b_oe_n;
   int pos = -1;
   // bit of position p is taken at the edge after p
   always @(posedge clk)
   begin
      if (pos >= 0 && pos < 512)
      begin
         a_d[pos] <= pin_a;
         a_oe_n[pos] <= pin_a_oe_n;
         b_d[pos] <= pin_b;
         b_oe_n[pos] <= pin_b_oe_n;
      end
      pos <= fsync ? 0 : (pos >= 0 ? pos + 1 : -1);
   end
endmodule : aptsm_host_rx
`default_nettype wire

/* verification/tb_top.sv */
// self-checking bench for the tx slot mapper
`include "aptsm_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import aptsm_pkg::*;
   localparam int W = 8;
   localparam int HB = 128;
   localparam logic [63:0] WORDS = 64'h963C0FF055AAC3A5;
   logic CLK = 0, RSTN = 0, CYC_I = 0, STB_I = 0, WE_I = 0, FSYNC = 0;
   logic [7:0] ADR_I = 8'h00;
   logic [3:0] SEL_I = 4'hF;
   logic [31:0] DAT_I = 32'h0, DAT_O;
   logic ACK_O, DOUT_A, DOUT_A_OE_N, SERIAL_OUT_B, SERIAL_OUT_B_OE_N;
   logic [63:0] CH_DATA = WORDS;
   int fails = 0, check_count = 0;
   always #2.5 CLK = ~CLK;
   aptsm_top #(.SLOT_BITS(W), .HALF_BITS(HB)) dut (.CLK(CLK), .RSTN(RSTN), .CYC_I(CYC_I), .STB_I(STB_I),
      .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .FSYNC(FSYNC),
      .CH_DATA(CH_DATA), .DOUT_A(DOUT_A), .DOUT_A_OE_N(DOUT_A_OE_N), .SERIAL_OUT_B(SERIAL_OUT_B),
      .SERIAL_OUT_B_OE_N(SERIAL_OUT_B_OE_N));
   aptsm_host_rx host (.clk(CLK), .fsync(FSYNC), .pin_a(DOUT_A), .pin_a_oe_n(DOUT_A_OE_N),
      .pin_b(SERIAL_OUT_B), .pin_b_oe_n(SERIAL_OUT_B_OE_N));
   task automatic stop_test;
      $display("fails=%0d checks=%0d", fails, check_count);
      if (fails == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wb(input logic we, input logic [5:0] idx, input logic [7:0] wd, output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge CLK);
      CYC_I <= 1'b1;
      STB_I <= 1'b1;
      WE_I <= we;
      ADR_I <= {idx, 2'b00};
      DAT_I <= {24'h000000, wd};
      do
      begin
         @(posedge CLK);
         n++;
      end
      while (ACK_O !== 1'b1 && n < 20);
      rd = DAT_O;
      CYC_I <= 1'b0;
      STB_I <= 1'b0;
      if (n >= 20)
      begin
         fails++;
         stop_test();
      end
   endtask : wb
   task automatic t_regs;
      logic [31:0] r;
      wb(0, `APTSM_IDX_CH1, 8'h00, r);
      chk(r, 32'h20);
      wb(0, `APTSM_IDX_ROUTE, 8'h00, r);
      chk(r, 32'h00);
      wb(0, `APTSM_IDX_OFFSET, 8'h00, r);
      chk(r, 32'h00);
      wb(0, `APTSM_IDX_FMT, 8'h00, r);
      chk(r, 32'h00);
      wb(1, `APTSM_IDX_OFFSET, 8'hFF, r);
      wb(0, `APTSM_IDX_OFFSET, 8'h00, r);
      chk(r, 32'h1F);
      wb(1, `APTSM_IDX_CH1, 8'hFF, r);
      wb(0, `APTSM_IDX_CH1, 8'h00, r);
      chk(r, 32'h3F);
      wb(1, `APTSM_IDX_ROUTE, 8'hFF, r);
      wb(0, `APTSM_IDX_ROUTE, 8'h00, r);
      chk(r, 32'hFF);
      wb(1, 6'h3F, 8'hFF, r);
      wb(0, 6'h3F, 8'h00, r);
      chk(r, 32'h00);
   endtask : t_regs
   task automatic lane_chk(input logic [1:0] fmt, input logic [4:0] off, input logic pin, input logic en,
      input logic [4:0] slot, input logic [7:0] word);
      int base;
      logic [7:0] d, oe;
      base = off + (fmt == 2'b01) + ((fmt == 2'b00 || slot < 16) ? slot * W : HB + (slot - 16) * W);
      for (int i = 0; i < W; i++)
      begin
         d[7-i] = pin ? host.b_d[base+i] : host.a_d[base+i];
         oe[7-i] = pin ? host.b_oe_n[base+i] : host.a_oe_n[base+i];
      end
      chk(oe, en ? 8'h00 : 8'hFF);
      if (en)
         chk(d, word);
   endtask : lane_chk
   task automatic t_frame(input logic [1:0] fmt, input logic [4:0] off, input logic [7:0] route,
      input logic [7:0] cfg);
      logic [31:0] r;
      int p;
      wb(1, `APTSM_IDX_FMT, {fmt, 6'h00}, r);
      wb(1, `APTSM_IDX_OFFSET, {3'h0, off}, r);
      wb(1, `APTSM_IDX_ROUTE, route, r);
      wb(1, `APTSM_IDX_CH1, cfg, r);
      @(posedge CLK);
      FSYNC <= 1'b1;
      @(posedge CLK);
      FSYNC <= 1'b0;
      repeat (520) @(posedge CLK);
      if (fmt == 2'b11)
      begin
         for (p = 0; p < 512; p++)
            if (host.a_oe_n[p] !== 1'b1 || host.b_oe_n[p] !== 1'b1)
               break;
         chk(32'(p), 32'd512);
         wb(0, `APTSM_IDX_STATUS, 8'h00, r);
         chk(r & 32'hFFFFFFE0, 32'h00000000);
      end
      else
      begin
         lane_chk(fmt, off, route[0], cfg[5], cfg[4:0], WORDS[7:0]);
         lane_chk(fmt, off, route[1], 1'b1, 5'h01, WORDS[15:8]);
      end
   endtask : t_frame
   initial
   begin
      repeat (8) @(posedge CLK);
      RSTN <= 1'b1;
      t_regs();
      t_frame(2'b00, 5'h00, 8'h00, 8'h20);
      t_frame(2'b00, 5'h1F, 8'h01, 8'h3F);
      t_frame(2'b01, 5'h03, 8'h02, 8'h30);
      t_frame(2'b10, 5'h05, 8'h03, 8'h2F);
      t_frame(2'b10, 5'h00, 8'h00, 8'h3F);
      t_frame(2'b00, 5'h00, 8'h00, 8'h00);
      t_frame(2'b11, 5'h00, 8'h00, 8'h20);
      stop_test();
   end
   initial
   begin
      repeat (20000) @(posedge CLK);
      fails++;
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
